// *** hw/cbpc_cfg.svh ***
`ifndef CBPC_CFG_SVH
`define CBPC_CFG_SVH

// wishbone register offsets (byte addresses, one word each)
`define CBPC_REG_CTRL        4'h0
`define CBPC_REG_STAT        4'h4
`define CBPC_ADR_W           4

// control register fields
`define CBPC_CTRL_DIS0       0
`define CBPC_CTRL_DIS1       1
`define CBPC_CTRL_RST        2'h0

// status register fields
`define CBPC_STAT_STARTED    0
`define CBPC_STAT_PWRDN      1
`define CBPC_STAT_MODE_LO    2
`define CBPC_STAT_MODE_HI    3
`define CBPC_STAT_ADDR_LO    4
`define CBPC_STAT_ADDR_HI    5
`define CBPC_STAT_ACT0       6
`define CBPC_STAT_ACT1       7

// tri-level pin codes as seen by the core
`define CBPC_TRI_LOW         2'h0
`define CBPC_TRI_MID         2'h1
`define CBPC_TRI_HIGH        2'h2
`define CBPC_TRI_FLOAT       2'h3

// management-bus target addresses, values arbitrary
`define CBPC_BUS_ADDR_LOW    7'h10
`define CBPC_BUS_ADDR_MID    7'h11
`define CBPC_BUS_ADDR_HIGH   7'h12
`define CBPC_BUS_ADDR_RST    7'h00

`define CBPC_DAT_ZERO        32'h0000_0000

`endif

// *** hw/cbpc_pkg.sv ***
`default_nettype none

package cbpc_pkg;

  typedef enum logic [1:0] {
    CBPC_ST_WAIT_FIRST,
    CBPC_ST_RUN,
    CBPC_ST_POWERDOWN
  } cbpc_state_t;

  typedef enum logic [1:0] {
    CBPC_MODE_HIBW,
    CBPC_MODE_BYPASS,
    CBPC_MODE_LOBW
  } cbpc_mode_t;

  typedef struct packed {
    cbpc_state_t state;
    logic        started;
    logic        powered_down;
    logic [1:0]  ctrl;
    logic        out0_p;
    logic        out0_n;
    logic        out1_p;
    logic        out1_n;
    cbpc_mode_t  loop_mode;
    logic [6:0]  bus_address;
    logic        ack;
    logic [31:0] dat;
  } cbpc_core_t;

  typedef struct packed {
    logic [1:0] held;
  } cbpc_strap_state_t;

endpackage : cbpc_pkg

`default_nettype wire

// *** hw/cbpc_strap_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface cbpc_strap_if;
  logic       capture;
  logic [1:0] pin_level;
  logic [1:0] held;

  modport ctrl_side (output capture, output pin_level, input held);
  modport latch_side (input capture, input pin_level, output held);
endinterface : cbpc_strap_if

`default_nettype wire

// *** hw/cbpc_strap.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cbpc_cfg.svh"

module cbpc_strap
  import cbpc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  cbpc_strap_if.latch_side   strap
);

  cbpc_strap_state_t st;
  cbpc_strap_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (strap.capture)
    begin
      // a floating pin is biased to the middle level
      if (strap.pin_level == `CBPC_TRI_FLOAT)
        next_st.held = `CBPC_TRI_MID;
      else
        next_st.held = strap.pin_level;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st.held <= `CBPC_TRI_MID;
    else
      st <= next_st;
  end

  assign strap.held = st.held;

endmodule : cbpc_strap

`default_nettype wire

// *** hw/cbpc_pin_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cbpc_cfg.svh"

// Summary of operation
// - pair zero outputs run while its enable pin is low and CBPC_CTRL_DIS0 is clear, stop while high
// - pair one has its own active-low enable, independent of pair zero
// - on every enable pin, one means disabled and zero means enabled
// - an undriven enable pin is pulled low, so the pair is enabled
// - first high on power-good captures all straps on the same edge that start-up begins
// - after start-up, power-good low puts the device into power-down
// - later highs leave power-down without a fresh strap capture
// - power-good is pulled high when undriven, so the device starts
// - address strap latched at start-up picks one of three bus addresses
// - mode strap latched at start-up picks high-bw, bypass or low-bw loop
// - undriven mode strap sits mid level, selecting bypass
module cbpc_pin_ctrl
  import cbpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        pair0_enable_n,
  input  wire logic        pair1_enable_n,
  input  wire logic        power_good_powerdown_n,
  input  wire logic [1:0]  bus_address_strap,
  input  wire logic [1:0]  loop_mode_strap,
  output logic             clk_out0_p,
  output logic             clk_out0_n,
  output logic             clk_out1_p,
  output logic             clk_out1_n,
  output logic [1:0]       loop_mode,
  output logic [6:0]       bus_address,
  output logic             powered_down,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  cbpc_core_t   st;
  cbpc_core_t   next_st;
  logic         first_start;
  logic         wb_req;
  logic         en0;
  logic         en1;
  logic [31:0]  stat_word;
  logic [31:0]  rd_word;

  cbpc_strap_if addr_if ();
  cbpc_strap_if mode_if ();

  assign addr_if.pin_level = bus_address_strap;
  assign mode_if.pin_level = loop_mode_strap;
  // both straps are taken on the same edge, only once per power-up
  assign addr_if.capture   = first_start;
  assign mode_if.capture   = first_start;

  cbpc_strap u_addr_strap
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .strap   (addr_if.latch_side)
  );

  cbpc_strap u_mode_strap
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .strap   (mode_if.latch_side)
  );

  function automatic cbpc_mode_t mode_decode(input logic [1:0] lvl);
    cbpc_mode_t m;
    case (lvl)
      `CBPC_TRI_HIGH: m = CBPC_MODE_HIBW;
      `CBPC_TRI_LOW:  m = CBPC_MODE_LOBW;
      default:        m = CBPC_MODE_BYPASS;
    endcase
    return m;
  endfunction : mode_decode

  function automatic logic [6:0] addr_decode(input logic [1:0] lvl);
    logic [6:0] a;
    case (lvl)
      `CBPC_TRI_HIGH: a = `CBPC_BUS_ADDR_HIGH;
      `CBPC_TRI_LOW:  a = `CBPC_BUS_ADDR_LOW;
      default:        a = `CBPC_BUS_ADDR_MID;
    endcase
    return a;
  endfunction : addr_decode

  // a pin left open reads high, so start-up proceeds by itself
  assign first_start = (st.state == CBPC_ST_WAIT_FIRST) && power_good_powerdown_n;
  assign wb_req      = wb_cyc_i && wb_stb_i && !st.ack;

  // one disables, zero enables; the board pull-down leaves an open pin enabled
  // a falling power-good parks the pairs on the very edge that enters power-down
  assign en0 = (st.state == CBPC_ST_RUN) && power_good_powerdown_n &&
               !pair0_enable_n && !st.ctrl[`CBPC_CTRL_DIS0];
  assign en1 = (st.state == CBPC_ST_RUN) && power_good_powerdown_n &&
               !pair1_enable_n && !st.ctrl[`CBPC_CTRL_DIS1];

  always_comb
  begin
    stat_word = `CBPC_DAT_ZERO;
    stat_word[`CBPC_STAT_STARTED] = st.started;
    stat_word[`CBPC_STAT_PWRDN]   = st.powered_down;
    stat_word[`CBPC_STAT_MODE_HI:`CBPC_STAT_MODE_LO] = st.loop_mode;
    stat_word[`CBPC_STAT_ADDR_HI:`CBPC_STAT_ADDR_LO] = addr_if.held;
    stat_word[`CBPC_STAT_ACT0]    = st.out0_p || st.out0_n;
    stat_word[`CBPC_STAT_ACT1]    = st.out1_p || st.out1_n;
  end

  always_comb
  begin
    rd_word = `CBPC_DAT_ZERO;
    case (wb_adr_i)
      `CBPC_REG_CTRL: rd_word[1:0] = st.ctrl;
      `CBPC_REG_STAT: rd_word      = stat_word;
      default:        rd_word      = `CBPC_DAT_ZERO;
    endcase
  end

  always_comb
  begin
    next_st = st;

    case (st.state)
      CBPC_ST_WAIT_FIRST:
      begin
        if (power_good_powerdown_n)
        begin
          next_st.state   = CBPC_ST_RUN;
          next_st.started = 1'b1;
        end
      end
      CBPC_ST_RUN:
      begin
        if (!power_good_powerdown_n)
          next_st.state = CBPC_ST_POWERDOWN;
      end
      CBPC_ST_POWERDOWN:
      begin
        // leaving power-down never re-captures the straps
        if (power_good_powerdown_n)
          next_st.state = CBPC_ST_RUN;
      end
      default:
      begin
        next_st.state = CBPC_ST_WAIT_FIRST;
      end
    endcase

    next_st.powered_down = (next_st.state == CBPC_ST_POWERDOWN);

    // outputs park low/low when off, so no runt half-cycle on stop
    next_st.out0_p = en0 && !st.out0_p;
    next_st.out0_n = en0 && st.out0_p;
    next_st.out1_p = en1 && !st.out1_p;
    next_st.out1_n = en1 && st.out1_p;

    // decoded from the held copies only, so pins moving later have no effect
    if (st.started)
    begin
      next_st.loop_mode   = mode_decode(mode_if.held);
      next_st.bus_address = addr_decode(addr_if.held);
    end

    // classic wishbone: ack one cycle after the request, dropped the next
    next_st.ack = wb_req;
    next_st.dat = `CBPC_DAT_ZERO;
    if (wb_req)
    begin
      if (!wb_we_i)
        next_st.dat = rd_word;
      else if (wb_adr_i == `CBPC_REG_CTRL && wb_sel_i[0])
        next_st.ctrl = wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.state        <= CBPC_ST_WAIT_FIRST;
      st.started      <= 1'b0;
      st.powered_down <= 1'b0;
      st.ctrl         <= `CBPC_CTRL_RST;
      st.out0_p       <= 1'b0;
      st.out0_n       <= 1'b0;
      st.out1_p       <= 1'b0;
      st.out1_n       <= 1'b0;
      st.loop_mode    <= CBPC_MODE_BYPASS;
      st.bus_address  <= `CBPC_BUS_ADDR_RST;
      st.ack          <= 1'b0;
      st.dat          <= `CBPC_DAT_ZERO;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign clk_out0_p   = st.out0_p;
  assign clk_out0_n   = st.out0_n;
  assign clk_out1_p   = st.out1_p;
  assign clk_out1_n   = st.out1_n;
  assign loop_mode    = st.loop_mode;
  assign bus_address  = st.bus_address;
  assign powered_down = st.powered_down;
  assign wb_dat_o     = st.dat;
  assign wb_ack_o     = st.ack;

  // checks
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_first_start;
    first_start;
  endsequence

  sequence s_pd_exit;
    (st.state == CBPC_ST_POWERDOWN) && power_good_powerdown_n;
  endsequence

  sequence s_resume;
    s_pd_exit ##1 en0;
  endsequence

  property p_pair0_off;
    pair0_enable_n |=> !clk_out0_p && !clk_out0_n;
  endproperty
  a_pair0_off: assert property (p_pair0_off) else $error("pair 0 drove while disabled");

  property p_pair1_off;
    pair1_enable_n |=> !clk_out1_p && !clk_out1_n;
  endproperty
  a_pair1_off: assert property (p_pair1_off) else $error("pair 1 drove while disabled");

  property p_pair0_runs;
    en0 |=> (clk_out0_p != $past(clk_out0_p)) && (clk_out0_n == $past(clk_out0_p));
  endproperty
  a_pair0_runs: assert property (p_pair0_runs) else $error("pair 0 not toggling while enabled");

  property p_pair1_runs;
    en1 ##1 en1 |=> clk_out1_p != clk_out1_n;
  endproperty
  a_pair1_runs: assert property (p_pair1_runs) else $error("pair 1 not complementary");

  property p_first_start;
    s_first_start |=> (st.state == CBPC_ST_RUN) ##1 (stat_word[`CBPC_STAT_STARTED]);
  endproperty
  a_first_start: assert property (p_first_start) else $error("first power-good did not start");

  property p_enter_pd;
    (st.state == CBPC_ST_RUN) && !power_good_powerdown_n |=> powered_down && !clk_out0_p && !clk_out1_p;
  endproperty
  a_enter_pd: assert property (p_enter_pd) else $error("power-down not entered");

  property p_exit_pd;
    s_pd_exit |=> !powered_down && $stable(mode_if.held) && $stable(addr_if.held);
  endproperty
  a_exit_pd: assert property (p_exit_pd) else $error("power-down exit wrong");

  property p_addr_hold;
    st.started && $past(st.started) |-> $stable(addr_if.held);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address strap changed after start");

  property p_mode_hold;
    $past(st.started, 3) |-> $stable(loop_mode) && $stable(bus_address);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("loop mode changed after start");

  property p_mode_float;
    s_first_start ##0 (loop_mode_strap == `CBPC_TRI_FLOAT) |-> ##2 loop_mode == CBPC_MODE_BYPASS;
  endproperty
  a_mode_float: assert property (p_mode_float) else $error("floating mode strap not bypass");

  property p_mode_decode;
    s_first_start ##0 (loop_mode_strap == `CBPC_TRI_HIGH) |-> ##2 loop_mode == CBPC_MODE_HIBW;
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("high mode strap not high-bw");

  property p_mode_latch;
    s_first_start ##0 (loop_mode_strap == `CBPC_TRI_LOW) |-> ##2 loop_mode == CBPC_MODE_LOBW;
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("low mode strap not low-bw");

  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack timing wrong");

  property p_pd_quiet;
    powered_down |-> !clk_out0_p && !clk_out0_n && !clk_out1_p && !clk_out1_n;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("outputs ran in power-down");

  property p_wait_quiet;
    (st.state == CBPC_ST_WAIT_FIRST) |-> !clk_out0_p && !clk_out1_p && !st.started;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("outputs ran before first start");

  property p_pd_hold;
    powered_down && !power_good_powerdown_n |=> powered_down;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down left while power-good low");

  property p_resume;
    s_resume |=> clk_out0_p;
  endproperty
  a_resume: assert property (p_resume) else $error("pair 0 did not resume after power-down");

  property p_addr_high;
    s_first_start ##0 (bus_address_strap == `CBPC_TRI_HIGH) |-> ##2 bus_address == `CBPC_BUS_ADDR_HIGH;
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("high address strap decoded wrong");

  property p_addr_low;
    s_first_start ##0 (bus_address_strap == `CBPC_TRI_LOW) |-> ##2 bus_address == `CBPC_BUS_ADDR_LOW;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("low address strap decoded wrong");

  property p_addr_float;
    s_first_start ##0 (bus_address_strap == `CBPC_TRI_FLOAT) |-> ##2 bus_address == `CBPC_BUS_ADDR_MID;
  endproperty
  a_addr_float: assert property (p_addr_float) else $error("floating address strap not mid");

  property p_mode_mid;
    s_first_start ##0 (loop_mode_strap == `CBPC_TRI_MID) |-> ##2 loop_mode == CBPC_MODE_BYPASS;
  endproperty
  a_mode_mid: assert property (p_mode_mid) else $error("mid mode strap not bypass");

  property p_pair0_gated;
    st.ctrl[`CBPC_CTRL_DIS0] |=> !clk_out0_p && !clk_out0_n;
  endproperty
  a_pair0_gated: assert property (p_pair0_gated) else $error("pair 0 ran while forced off");

  property p_pair1_gated;
    st.ctrl[`CBPC_CTRL_DIS1] |=> !clk_out1_p && !clk_out1_n;
  endproperty
  a_pair1_gated: assert property (p_pair1_gated) else $error("pair 1 ran while forced off");

endmodule : cbpc_pin_ctrl

`default_nettype wire

// *** sim/cbpc_board.sv ***
`timescale 1ns/1ps
`default_nettype none

// board side: a released pin settles at its pull level, never at the last driven value
module cbpc_board
  import cbpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [2:0] drive,
  input  wire logic [2:0] level,
  input  wire logic [1:0] addr_lvl,
  input  wire logic [1:0] mode_lvl,
  output logic            pg_n,
  output logic            en0_n,
  output logic            en1_n,
  output logic [1:0]      addr_strap,
  output logic [1:0]      mode_strap
);
  initial
  begin
    pg_n = 1'b0;
    en0_n = 1'b0;
    en1_n = 1'b0;
    addr_strap = 2'h1;
    mode_strap = 2'h1;
  end
  always @(posedge clk)
  begin
    pg_n <= drive[2] ? level[2] : 1'b1;
    en1_n <= drive[1] ? level[1] : 1'b0;
    en0_n <= drive[0] ? level[0] : 1'b0;
    addr_strap <= addr_lvl;
    mode_strap <= mode_lvl; // code 3 is a floating pin, biased to mid by the core
  end
endmodule : cbpc_board

`default_nettype wire

// *** sim/clock_buffer_pin_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cbpc_cfg.svh"

module clock_buffer_pin_control_bench
  import cbpc_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  drive = 3'h7;
  logic [2:0]  level = 3'h0;
  logic [1:0]  addr_lvl = 2'h0;
  logic [1:0]  mode_lvl = 2'h0;
  logic        pg_n, en0_n, en1_n;
  logic [1:0]  a_strap, m_strap, loop_mode;
  logic        o0p, o0n, o1p, o1n, powered_down, wb_ack;
  logic [6:0]  bus_address;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [3:0]  wb_adr = 4'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_rd, rd;
  int          fails = 0;
  int          check_count = 0;
  logic [1:0]  mode_tab [4] = '{2'h2, 2'h1, 2'h0, 2'h1};
  logic [6:0]  adr_tab [4] = '{`CBPC_BUS_ADDR_LOW, `CBPC_BUS_ADDR_MID, `CBPC_BUS_ADDR_HIGH, `CBPC_BUS_ADDR_MID};

  always #5 clk = ~clk;

  cbpc_board u_board (.clk(clk), .drive(drive), .level(level), .addr_lvl(addr_lvl), .mode_lvl(mode_lvl),
    .pg_n(pg_n), .en0_n(en0_n), .en1_n(en1_n), .addr_strap(a_strap), .mode_strap(m_strap));

  cbpc_pin_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .pair0_enable_n(en0_n), .pair1_enable_n(en1_n),
    .power_good_powerdown_n(pg_n), .bus_address_strap(a_strap), .loop_mode_strap(m_strap),
    .clk_out0_p(o0p), .clk_out0_n(o0n), .clk_out1_p(o1p), .clk_out1_n(o1n), .loop_mode(loop_mode),
    .bus_address(bus_address), .powered_down(powered_down), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // values are read right after the edge, so they are the ones the design held at it
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] wd);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'h3, we, adr, sel, wd};
    // no cycle count assumed: only the watchdog ends a stuck wait
    do
    begin
      @(posedge clk);
    end
    while (wb_ack !== 1'b1);
    rd = wb_rd;
    {wb_cyc, wb_stb} <= 2'h0;
    @(posedge clk);
  endtask : wb

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(loop_mode, 2'h1);
    check(bus_address, 7'h00);
    check({powered_down, o0p, o0n}, 3'h0);
  endtask : do_reset

  // one pass per strap code, code 3 being a floating pin
  task automatic t_straps;
    for (int i = 0; i < 4; i++)
    begin
      {addr_lvl, mode_lvl, level[2]} <= {i[1:0], i[1:0], 1'b0};
      do_reset();
      level[2] <= 1'b1;
      repeat (8) @(posedge clk);
      check(bus_address, adr_tab[i]);
      check(loop_mode, mode_tab[i]);
      wb(1'b0, `CBPC_REG_STAT, 4'hf, 32'h0);
      check({rd[3:2], rd[0]}, {mode_tab[i], 1'b1});
    end
  endtask : t_straps

  task automatic pairs(input logic [1:0] off);
    logic a0, a1;
    @(posedge clk);
    {a0, a1} = {o0p, o1p};
    @(posedge clk);
    check({a0 ^ o0p, o0p | o0n, o0p & o0n}, {~off[0], ~off[0], 1'b0});
    check({a1 ^ o1p, o1p | o1n, o1p & o1n}, {~off[1], ~off[1], 1'b0});
  endtask : pairs

  task automatic t_enables;
    for (int i = 0; i < 4; i++)
    begin
      level[1:0] <= i[1:0];
      repeat (4) @(posedge clk);
      pairs(i[1:0]);
    end
    level[1:0] <= 2'h0;
    wb(1'b1, `CBPC_REG_CTRL, 4'h1, 32'h1);
    wb(1'b1, `CBPC_REG_CTRL, 4'he, 32'h2);
    wb(1'b1, 4'h8, 4'hf, 32'h3);
    wb(1'b0, `CBPC_REG_CTRL, 4'hf, 32'h0);
    check(rd, 32'h1);
    wb(1'b0, 4'h8, 4'hf, 32'h0);
    check(rd, 32'h0);
    pairs(2'h1);
    wb(1'b1, `CBPC_REG_CTRL, 4'h1, 32'h2);
    pairs(2'h2);
    wb(1'b1, `CBPC_REG_CTRL, 4'h1, 32'h0);
  endtask : t_enables

  task automatic t_powerdown;
    logic [8:0] held;
    held = {bus_address, loop_mode};
    level[2] <= 1'b0;
    {addr_lvl, mode_lvl} <= 4'h5;
    repeat (4) @(posedge clk);
    check(powered_down, 1'b1);
    level[2] <= 1'b1;
    repeat (4) @(posedge clk);
    check(powered_down, 1'b0);
    check({bus_address, loop_mode}, held);
    pairs(2'h0);
  endtask : t_powerdown

  task automatic t_undriven;
    drive <= 3'h0;
    mode_lvl <= 2'h3;
    do_reset();
    repeat (6) @(posedge clk);
    check(loop_mode, 2'h1);
    check(bus_address, `CBPC_BUS_ADDR_MID);
    pairs(2'h0);
  endtask : t_undriven

  initial
  begin
    repeat (5) @(posedge clk);
    t_straps();
    t_enables();
    t_powerdown();
    t_undriven();
    give_verdict();
  end

  initial
  begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule : clock_buffer_pin_control_bench

`default_nettype wire
